// >>> hdl/serial_pkg.sv
// constants, register map and carrier types for the synchronous slave serial port
// assumes a 10 mhz system clock and an ahb-lite bus with 32-bit data
package serial_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] TX_CTL_OFS = 8'h00; // transmit status and control
  localparam logic [7:0] RX_CTL_OFS = 8'h04; // receive status and control
  localparam logic [7:0] RX_DATA_OFS = 8'h08; // receive data, read pops
  localparam logic [7:0] TX_DATA_OFS = 8'h0c; // transmit data, write loads
  localparam logic [7:0] FLAGS_OFS = 8'h10; // flags and interrupt enables

  // flag register bit positions
  localparam int RX_FLAG_BIT = 0; // receive interrupt flag, read only
  localparam int TX_FLAG_BIT = 1; // transmit interrupt flag, read only
  localparam int RX_IE_BIT = 4; // receive interrupt enable
  localparam int TX_IE_BIT = 5; // transmit interrupt enable

  ////////////////////////////////////////////////////////////////////////////
  // control register layouts, bit 7 first
  typedef struct packed {
    logic clock_source_select;
    logic nine_bit_transmit;
    logic transmit_enable;
    logic sync_mode;
    logic break_send;
    logic high_baud_select;
    logic shift_register_empty;
    logic transmit_ninth_bit;
  } tx_ctl_t;

  typedef struct packed {
    logic serial_port_enable;
    logic nine_bit_receive;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic address_detect;
    logic framing_error;
    logic overrun_flag;
    logic received_ninth_bit;
  } rx_ctl_t;

  // reset values
  localparam logic [7:0] TX_CTL_RESET = 8'h02; // shift register empty reads one
  localparam logic [7:0] RX_CTL_RESET = 8'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  // captured ahb address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
  } bus_req_t;

  ////////////////////////////////////////////////////////////////////////////
  // character and timing figures
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
  localparam logic [3:0] BREAK_BITS = 4'he; // start, twelve zeros, stop
  localparam int CLK_PERIOD_NS = 100;
  localparam int BREAK_BIT_NS = 8000;
  localparam int BREAK_BIT_CYCLES = (BREAK_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // break generator states
  typedef enum logic [0:0] {
    BRK_IDLE,
    BRK_SEND
  } brk_state_t;

endpackage

// >>> hdl/pin_sync.sv
// two-flop synchronisers for pin inputs, one per bit
// assumes inputs are asynchronous to hclk; the first flop feeds only the second
module pin_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  ////////////////////////////////////////////////////////////////////////////
  // one two-stage chain per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q; // first stage, read only by second
      logic stable_q; // second stage
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_q <= 1'h0;
          stable_q <= 1'h0;
        end else if (ce) begin
          meta_q <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule

// >>> hdl/rx_fifo.sv
// two-entry receive fifo of nine-bit characters, top entry held in a register
// assumes push is never raised on a full fifo unless pop is raised too
module rx_fifo (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic flush,
  // write side
  input wire logic push,
  input wire logic [8:0] wdata,
  // read side
  input wire logic pop,
  output logic [8:0] top_q,
  output logic empty,
  output logic full
);

  logic [8:0] second_q; // entry behind the top
  logic [1:0] count_q; // characters held

  assign empty = (count_q == 2'h0);
  assign full = (count_q == 2'h2);

  ////////////////////////////////////////////////////////////////////////////
  // storage and count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      top_q <= 9'h000;
      second_q <= 9'h000;
      count_q <= 2'h0;
    end else if (ce) begin
      if (flush) begin
        count_q <= 2'h0;
      end else if (push && (!pop || empty)) begin
        // plain write into the first free entry
        if (empty) begin
          top_q <= wdata;
        end else begin
          second_q <= wdata;
        end
        count_q <= count_q + 2'h1;
      end else if (push) begin
        // write and read together, count unchanged
        if (count_q == 2'h1) begin
          top_q <= wdata;
        end else begin
          top_q <= second_q;
          second_q <= wdata;
        end
      end else if (pop && !empty) begin
        // read moves the second entry up
        top_q <= second_q;
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule

// >>> hdl/sync_slave_serial.sv
// synchronous slave serial port: ahb-lite registers, receive and transmit shift paths
// assumes the external master drives an idle-low clock on the clock pin
// assumes hclk keeps running; sleep_mode only tells the port the core is asleep
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.

// How it works
// (RULE1) continuous receive keeps receiver on; single receive ignored
// (RULE2) completed word moves into receive data fifo
// (RULE3) received character while asleep raises wake request
// (RULE4) software sets mode bits, continuous receive last
// (RULE5) receive flag set on completion, interrupt if enabled
// (RULE6) software reads ninth bit before low byte
// (RULE7) overrun clears with continuous receive or port off
// (RULE8) only slave mode shifts during sleep
// (RULE9) slave shift registers clocked only by clock pin
// (RULE10) software empties receive fifo before sleeping
// (RULE11) full word clocked in sets receive flag, wakes
// (RULE12) software fills transmit path and enables before sleep
// (RULE13) shifted-out word reloads from buffer, sets transmit flag
// (RULE14) writing transmit data clears transmit flag
// (RULE15) break sends start, twelve zeros, stop; self-clears
// (RULE16) two-entry fifo; third character sets overrun, stalls
// (RULE17) receive data sampled on trailing clock edge
// (RULE18) transmit data changes on leading clock edge
// (RULE19) shift register empty reads one when idle
// (RULE20) ninth transmit bit sent after the eight data bits
module sync_slave_serial (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // clock pin
  input wire logic clock_pin_in,
  output logic clock_pin_out,
  output logic clock_pin_oe,
  // data pin
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  // core power state and requests
  input wire logic sleep_mode,
  output logic rx_irq,
  output logic tx_irq,
  output logic wake
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  serial_pkg::tx_ctl_t tx_ctl_q; // transmit control, empty bit unused here
  serial_pkg::rx_ctl_t rx_ctl_q; // receive control, status bits unused here
  logic [5:0] flags_q; // only enable bits are stored
  serial_pkg::bus_req_t req_q; // data phase in flight
  logic accept; // address phase taken
  logic mapped; // address hits a register
  logic [7:0] rd_mux; // read value chosen at address phase
  logic wr_tx_ctl, wr_rx_ctl, wr_flags, wr_tx_data; // data-phase writes
  logic pop; // receive data read
  logic [1:0] pins_s; // synchronised clock and data pins
  logic ck_s, dt_s, ck_prev_q, rise, fall; // clock edge finder
  logic slave, rx_on, tx_on; // mode decode
  logic [8:0] rsr_q; // receive shift register
  logic [3:0] rx_cnt_q; // bits received so far
  logic [3:0] rx_last; // index of last bit
  logic [8:0] rsr_next, rx_char; // shifted value, finished char
  logic rx_done, push, overrun_q;
  logic [8:0] fifo_top;
  logic fifo_empty, fifo_full;
  logic [7:0] tx_buf_q; // transmit data register
  logic tx_buf_full_q;
  logic [8:0] tsr_q; // transmit shift register
  logic [3:0] tx_left_q; // bits still to drive
  logic tx_busy_q, load, dout_q;
  serial_pkg::brk_state_t brk_state_q;
  logic [7:0] brk_tick_q;
  logic [3:0] brk_bit_q;
  logic start_break, brk_done, brk_low;
  logic rx_flag, tx_flag, rx_irq_d, tx_irq_d;

  ////////////////////////////////////////////////////////////////////////////
  // bus address phase and read mux
  assign accept = hsel && hready && htrans[1];
  assign mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0) && (haddr[7:0] <= serial_pkg::FLAGS_OFS);
  assign pop = accept && !hwrite && mapped && (haddr[7:0] == serial_pkg::RX_DATA_OFS);

  // read mux, reserved and unmapped read zero
  always_comb begin
    rd_mux = 8'h00;
    if (mapped) begin
      case (haddr[7:0])
        serial_pkg::TX_CTL_OFS: rd_mux = {tx_ctl_q[7:2], !tx_busy_q, tx_ctl_q[0]}; // RULE19
        serial_pkg::RX_CTL_OFS: rd_mux = {rx_ctl_q[7:3], 1'h0, overrun_q, fifo_top[8]};
        serial_pkg::RX_DATA_OFS: rd_mux = fifo_top[7:0];
        serial_pkg::FLAGS_OFS: rd_mux = {2'h0, flags_q[5:4], 2'h0, tx_flag, rx_flag};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // capture request, answer with zero wait and okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end else if (ce) begin
      req_q.valid <= accept && mapped;
      req_q.write <= hwrite;
      req_q.offset <= haddr[7:0];
      if (accept && !hwrite) begin
        hrdata <= {24'h000000, rd_mux};
      end
    end
  end

  // data-phase write strobes
  assign wr_tx_ctl = req_q.valid && req_q.write && (req_q.offset == serial_pkg::TX_CTL_OFS);
  assign wr_rx_ctl = req_q.valid && req_q.write && (req_q.offset == serial_pkg::RX_CTL_OFS);
  assign wr_flags = req_q.valid && req_q.write && (req_q.offset == serial_pkg::FLAGS_OFS);
  assign wr_tx_data = req_q.valid && req_q.write && (req_q.offset == serial_pkg::TX_DATA_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // control registers; hardware clears break send when the break ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ctl_q <= serial_pkg::TX_CTL_RESET;
      rx_ctl_q <= serial_pkg::RX_CTL_RESET;
      flags_q <= serial_pkg::FLAGS_RESET;
    end else if (ce) begin
      if (wr_tx_ctl) begin
        tx_ctl_q <= {hwdata[7:2], 1'h1, hwdata[0]};
      end else if (brk_done) begin
        tx_ctl_q.break_send <= 1'h0; // RULE15
      end
      if (wr_rx_ctl) begin
        rx_ctl_q <= {hwdata[7:3], 3'h0};
      end
      if (wr_flags) begin
        flags_q <= {hwdata[5:4], 4'h0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and clock edges
  pin_sync #(.WIDTH(2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .async_in({data_pin_in, clock_pin_in}),
    .sync_out(pins_s)
  );
  assign ck_s = pins_s[0];
  assign dt_s = pins_s[1];

  // previous clock level for edge finding
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_prev_q <= 1'h0;
    end else if (ce) begin
      ck_prev_q <= ck_s;
    end
  end
  assign rise = ck_s && !ck_prev_q; // leading edge
  assign fall = !ck_s && ck_prev_q; // trailing edge

  // mode decode: shifting runs only from the pin clock in slave mode
  assign slave = rx_ctl_q.serial_port_enable && tx_ctl_q.sync_mode && !tx_ctl_q.clock_source_select; // RULE8 RULE9
  assign rx_on = slave && rx_ctl_q.continuous_receive_enable; // RULE1
  assign tx_on = slave && !rx_ctl_q.continuous_receive_enable && !rx_ctl_q.single_receive_enable
                 && tx_ctl_q.transmit_enable;

  ////////////////////////////////////////////////////////////////////////////
  // receive shift path, lsb first
  assign rx_last = rx_ctl_q.nine_bit_receive ? (serial_pkg::BITS9 - 4'h1) : (serial_pkg::BITS8 - 4'h1);
  assign rsr_next = {dt_s, rsr_q[8:1]};
  assign rx_char = rx_ctl_q.nine_bit_receive ? rsr_next : {1'h0, rsr_next[8:1]};
  assign rx_done = rx_on && fall && !overrun_q && (rx_cnt_q == rx_last); // RULE11
  assign push = rx_done && (!fifo_full || pop); // RULE2

  // shift on trailing edge; partial char dropped when receive is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsr_q <= 9'h000;
      rx_cnt_q <= 4'h0;
    end else if (ce) begin
      if (!rx_on) begin
        rx_cnt_q <= 4'h0;
      end else if (fall && !overrun_q) begin
        rsr_q <= rsr_next; // RULE17
        rx_cnt_q <= (rx_cnt_q == rx_last) ? 4'h0 : rx_cnt_q + 4'h1;
      end
    end
  end

  // overrun: set wins, cleared by receive off or port off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_q <= 1'h0;
    end else if (ce) begin
      if (rx_done && fifo_full && !pop) begin
        overrun_q <= 1'h1; // RULE16
      end else if (!rx_ctl_q.continuous_receive_enable || !rx_ctl_q.serial_port_enable) begin
        overrun_q <= 1'h0; // RULE7
      end
    end
  end

  // port off acts as a module reset of the fifo
  rx_fifo u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .flush(!rx_ctl_q.serial_port_enable),
    .push(push),
    .wdata(rx_char),
    .pop(pop),
    .top_q(fifo_top),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer; a new write wins over a reload in the same cycle
  assign load = tx_on && tx_buf_full_q && !tx_busy_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf_q <= 8'h00;
      tx_buf_full_q <= 1'h0;
    end else if (ce) begin
      if (!rx_ctl_q.serial_port_enable) begin
        tx_buf_full_q <= 1'h0;
      end else if (wr_tx_data && !start_break) begin
        tx_buf_q <= hwdata[7:0];
        tx_buf_full_q <= 1'h1; // RULE14
      end else if (load) begin
        tx_buf_full_q <= 1'h0; // RULE13
      end
    end
  end

  // transmit shift register: drive on leading edge, free after trailing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tsr_q <= 9'h000;
      tx_left_q <= 4'h0;
      tx_busy_q <= 1'h0;
      dout_q <= 1'h0;
    end else if (ce) begin
      if (!tx_on) begin
        tx_busy_q <= 1'h0;
        tx_left_q <= 4'h0;
      end else if (load) begin
        tsr_q <= {tx_ctl_q.transmit_ninth_bit, tx_buf_q}; // RULE20
        tx_left_q <= tx_ctl_q.nine_bit_transmit ? serial_pkg::BITS9 : serial_pkg::BITS8;
        tx_busy_q <= 1'h1; // RULE13
      end else if (tx_busy_q && rise && (tx_left_q != 4'h0)) begin
        dout_q <= tsr_q[0]; // RULE18
        tsr_q <= {1'h0, tsr_q[8:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end else if (tx_busy_q && fall && (tx_left_q == 4'h0)) begin
        tx_busy_q <= 1'h0; // RULE19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // asynchronous break generator on the clock pin, halted in sleep
  assign start_break = wr_tx_data && rx_ctl_q.serial_port_enable && !tx_ctl_q.sync_mode
                       && tx_ctl_q.transmit_enable && tx_ctl_q.break_send && (brk_state_q == serial_pkg::BRK_IDLE);
  assign brk_done = (brk_state_q == serial_pkg::BRK_SEND) && !sleep_mode
                    && (brk_tick_q == 8'(serial_pkg::BREAK_BIT_CYCLES - 1)) && (brk_bit_q == serial_pkg::BREAK_BITS - 4'h1);
  assign brk_low = (brk_state_q == serial_pkg::BRK_SEND) && (brk_bit_q != serial_pkg::BREAK_BITS - 4'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_state_q <= serial_pkg::BRK_IDLE;
      brk_tick_q <= 8'h00;
      brk_bit_q <= 4'h0;
    end else if (ce) begin
      case (brk_state_q)
        serial_pkg::BRK_IDLE: begin
          brk_tick_q <= 8'h00;
          brk_bit_q <= 4'h0;
          if (start_break) begin
            brk_state_q <= serial_pkg::BRK_SEND; // RULE15
          end
        end
        serial_pkg::BRK_SEND: begin
          if (!rx_ctl_q.serial_port_enable) begin
            brk_state_q <= serial_pkg::BRK_IDLE;
          end else if (!sleep_mode) begin // RULE8
            if (brk_tick_q == 8'(serial_pkg::BREAK_BIT_CYCLES - 1)) begin
              brk_tick_q <= 8'h00;
              brk_bit_q <= brk_bit_q + 4'h1;
              if (brk_done) begin
                brk_state_q <= serial_pkg::BRK_IDLE;
              end
            end else begin
              brk_tick_q <= brk_tick_q + 8'h01;
            end
          end
        end
        default: brk_state_q <= serial_pkg::BRK_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, requests and pin drivers
  assign rx_flag = !fifo_empty; // RULE5
  assign tx_flag = !tx_buf_full_q;
  assign rx_irq_d = rx_flag && flags_q[serial_pkg::RX_IE_BIT]; // RULE5
  assign tx_irq_d = tx_flag && flags_q[serial_pkg::TX_IE_BIT];

  // registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_irq <= 1'h0;
      tx_irq <= 1'h0;
      wake <= 1'h0;
      clock_pin_out <= 1'h1;
      clock_pin_oe <= 1'h0;
      data_pin_oe <= 1'h0;
    end else if (ce) begin
      rx_irq <= rx_irq_d;
      tx_irq <= tx_irq_d;
      wake <= sleep_mode && (rx_irq_d || tx_irq_d); // RULE3
      clock_pin_out <= !brk_low;
      clock_pin_oe <= rx_ctl_q.serial_port_enable && !tx_ctl_q.sync_mode && tx_ctl_q.transmit_enable; // RULE9
      data_pin_oe <= tx_on;
    end
  end
  assign data_pin_out = dout_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions and covers
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  rx_push_a: assert property (ce && rx_done && !fifo_full |=> !fifo_empty) else $error("char not stored"); // RULE2
  rx_irq_a: assert property ((ce && push && flags_q[serial_pkg::RX_IE_BIT] ##1 ce && flags_q[serial_pkg::RX_IE_BIT])
    |=> rx_irq) else $error("no receive request"); // RULE5
  wake_rx_a: assert property ((ce && push && sleep_mode && flags_q[serial_pkg::RX_IE_BIT] ##1 ce && sleep_mode)
    |=> wake) else $error("no wake on receive"); // RULE3
  ovr_set_a: assert property (ce && rx_done && fifo_full && !pop |=> overrun_q && fifo_full)
    else $error("overrun not set"); // RULE16
  ovr_stall_a: assert property (overrun_q |-> !push) else $error("push during overrun"); // RULE16
  ovr_clear_a: assert property (ce && !rx_done && !rx_ctl_q.continuous_receive_enable |=> !overrun_q)
    else $error("overrun not cleared"); // RULE7
  sample_fall_a: assert property (ce && rx_on && fall && !overrun_q |=> rsr_q[8] == $past(dt_s))
    else $error("bad sample"); // RULE17
  tx_edge_a: assert property (ce && !rise |=> $stable(data_pin_out)) else $error("data moved off edge"); // RULE18
  reload_a: assert property (ce && load && !wr_tx_data |=> tx_busy_q && tx_flag) else $error("no reload"); // RULE13
  tx_clear_a: assert property (ce && wr_tx_data && !start_break && rx_ctl_q.serial_port_enable |=> !tx_flag)
    else $error("flag not cleared"); // RULE14
  ninth_a: assert property (ce && load && tx_ctl_q.nine_bit_transmit |=> tsr_q[8] == $past(tx_ctl_q.transmit_ninth_bit)
    && tx_left_q == serial_pkg::BITS9) else $error("ninth bit lost"); // RULE20
  slave_oe_a: assert property (ce && slave |=> !clock_pin_oe) else $error("clock pin driven in slave"); // RULE9
  sleep_hold_a: assert property (ce && sleep_mode && brk_state_q == serial_pkg::BRK_SEND |=> $stable(brk_tick_q))
    else $error("break ran in sleep"); // RULE8
  brk_end_a: assert property (ce && brk_done && !wr_tx_ctl |=> !tx_ctl_q.break_send && clock_pin_out)
    else $error("break not ended"); // RULE15

  rx_char_c: cover property (push);
  overrun_c: cover property (ce && rx_done && fifo_full && !pop);
  reload_c: cover property (load ##[1:200] load);
  break_c: cover property (brk_done);

endmodule

// >>> tb/link_master.sv
// external synchronous master on the slave serial link
// assumes idle-low clock, 800 ns period, lsb first
module link_master (
  // data wire level at the pin
  input wire logic data_wire,
  // master-driven lines
  output logic sclk,
  output logic sdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one character, exactly one clock per bit, clock idle between frames
  task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h000;
    #10;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      sdata = tx[i];
      #400;
      sclk = 1'b0;
      rx[i] = data_wire;
      #400;
    end
    sdata = ~sdata; // line inverted after the frame so no stale bit shows
  endtask
endmodule

// >>> tb/sync_slave_serial_bench.sv
// self-checking bench: ahb-lite register tasks plus link master model
// assumes a 100 ns hclk and zero-wait slave
module sync_slave_serial_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, sleep_mode = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, ck_out, ck_oe, dt_out, dt_oe, rx_irq, tx_irq, wake, sclk, sdata;
  logic [8:0] got;
  int mismatches = 0, comparisons = 0;
  // pin levels from all drivers
  wire ck_wire = ck_oe ? ck_out : sclk;
  wire dt_wire = dt_oe ? dt_out : sdata;
  always #50 hclk = ~hclk;
  sync_slave_serial sync_slave_serial_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clock_pin_in(ck_wire), .clock_pin_out(ck_out),
    .clock_pin_oe(ck_oe), .data_pin_in(dt_wire), .data_pin_out(dt_out), .data_pin_oe(dt_oe),
    .sleep_mode(sleep_mode), .rx_irq(rx_irq), .tx_irq(tx_irq), .wake(wake));
  link_master link_master_i (.data_wire(dt_wire), .sclk(sclk), .sdata(sdata));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single transfer, idle cycle first so writes land before reads
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #3000000;
    mismatches++;
    wrap_up();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [8:0] exp9 [2];
    exp9 = '{9'h13c, 9'h15a};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("tx ctl", 8'h00, 32'h02);
    chk("hresp", {31'h0, hresp}, 32'h0);
    rdchk("flags", 8'h10, 32'h02);
    rdchk("unmapped", 8'h14, 32'h0);
    // slave receive set-up, continuous receive last, single receive set too
    bus(1'b1, 8'h04, 32'h80);
    bus(1'b1, 8'h00, 32'h10);
    bus(1'b1, 8'h10, 32'h10);
    bus(1'b1, 8'h04, 32'hb0);
    rdchk("flags", 8'h10, 32'h12);
    sleep_mode <= 1'b1;
    link_master_i.xfer(9'h0a5, 8, got);
    repeat (3) @(posedge hclk);
    chk("rx irq", {31'h0, rx_irq}, 32'h1);
    chk("wake", {31'h0, wake}, 32'h1);
    rdchk("flags", 8'h10, 32'h13);
    rdchk("rx data", 8'h08, 32'ha5);
    // three characters, fifo holds two
    for (int i = 1; i < 4; i++) link_master_i.xfer(9'(i * 17), 8, got);
    rdchk("rx ctl", 8'h04, 32'hb2);
    rdchk("rx data", 8'h08, 32'h11);
    rdchk("rx data", 8'h08, 32'h22);
    bus(1'b1, 8'h04, 32'h80);
    rdchk("rx ctl", 8'h04, 32'h80);
    // nine-bit receive
    bus(1'b1, 8'h04, 32'hd0);
    link_master_i.xfer(9'h1c3, 9, got);
    rdchk("rx ctl", 8'h04, 32'hd1);
    rdchk("rx data", 8'h08, 32'hc3);
    // slave transmit, nine bits, two bytes queued
    bus(1'b1, 8'h04, 32'h80);
    bus(1'b1, 8'h00, 32'h71);
    bus(1'b1, 8'h10, 32'h20);
    bus(1'b1, 8'h0c, 32'h3c);
    bus(1'b1, 8'h0c, 32'h5a);
    chk("data oe", {31'h0, dt_oe}, 32'h1);
    rdchk("flags", 8'h10, 32'h20);
    rdchk("tx ctl", 8'h00, 32'h71);
    for (int i = 0; i < 2; i++) begin
      link_master_i.xfer(9'h0, 9, got);
      chk("tx char", {23'h0, got}, {23'h0, exp9[i]});
      repeat (3) @(posedge hclk);
      chk("tx irq", {31'h0, tx_irq & wake}, 32'h1);
    end
    rdchk("tx ctl", 8'h00, 32'h73);
    // asynchronous break
    sleep_mode <= 1'b0;
    bus(1'b1, 8'h00, 32'h28);
    bus(1'b1, 8'h0c, 32'h00);
    repeat (100) @(posedge hclk);
    chk("break low", {30'h0, ck_oe, ck_out}, 32'h2);
    repeat (serial_pkg::BREAK_BIT_CYCLES * 14) @(posedge hclk);
    chk("break end", {31'h0, ck_out}, 32'h1);
    rdchk("tx ctl", 8'h00, 32'h22);
    wrap_up();
  end
endmodule
